// ===== rtl/sfc_dev.sv
/*
  sfc_dev: frame and state control of the converter end: fall counting,
  sample hold, conversion result with offset correction, and data launch.
  Assumes sclk and cs_b come from the host, rst_b is the power-up reset,
  and the user side gives the held input code and the isolated offset code.
  cs_b is used unsynchronised, as frame start and frame clear: the link
  clock stands still between frames, so nothing could clock a synchroniser.
  sclk must stand high when cs_b moves; cen should not drop inside a frame,
  or the fall count slips against the host's.
*/
// Notes on behaviour
// R1: power-up starts in sampling state, switches closed
// R2: frame is cs low; clock only counted then
// R3: data output floats while chip select high
// R4: chip select fall freezes input, starts converting
// R5: host gives at least 18 falls per frame
// R6: return to sampling; host waits sampling time
// R7: first frame after power-up shifts out zeros
// R8: frame shifts out previous frame's result
// R9: leading zero driven at chip select fall
// R10: msb on rise after first fall, then onward
// R11: zeros after all 14 result bits
// R12: short frame makes next word invalid
// R13: trim isolates inputs, correction kept until power-off
// R14: host calibrates at power-up and on drift
// R15: first frame of 24 clocks calibrates, zeros out
// R16: early rise in power-up trim aborts it
// R17: 64-clock frame calibrates; result first, zeros after
// R18: between 18 and 64 clocks aborts trim
// R19: sampling resumes after conversion or calibration
// R20: result is two's complement, saturating
// R21: falls counted from each frame start
`timescale 1ns/10ps
`default_nettype none

module sfc_dev (
  // power-up reset and freeze
  input  wire logic                     rst_b,
  input  wire logic                     cen,
  // link
  sfc_link_if.dev                       lnk,
  // analog stand-ins
  input  wire logic [13:0]              ain_code,
  input  wire logic [13:0]              zero_code,
  // status
  output var  sfc_pkg::sfc_state_e      state,
  output logic                          switches_closed,
  output logic [13:0]                   trim_code,
  output logic [13:0]                   last_result,
  output logic                          word_invalid
);
  import sfc_pkg::*;

  // ****************************************
  // storage
  // ****************************************
  logic [CNT_W-1:0] nf_q;
  logic             first_q;
  logic             frame_first_q;
  logic             done_q;
  logic             stale_q;
  logic [13:0]      hold_q;
  logic [13:0]      result_q;
  logic [13:0]      trim_q;
  logic [13:0]      word_q;
  logic             sdo_q;

  // corrected code clipped into the 14-bit two's complement range
  function automatic logic [13:0] sat_sub(input logic [13:0] a, input logic [13:0] b);
    logic signed [14:0] d;
    d = 15'(signed'(a)) - 15'(signed'(b));
    if (d > 15'(signed'(POS_FULL_CODE)))
      sat_sub = POS_FULL_CODE;
    else if (d < 15'(signed'(NEG_FULL_CODE)))
      sat_sub = NEG_FULL_CODE;
    else
      sat_sub = d[13:0];
  endfunction

  // true on the fall that takes the count up to n
  function automatic logic fall_reaches(input logic [CNT_W-1:0] cnt, input logic [CNT_W-1:0] n);
    fall_reaches = (cnt == n - FIRST_BIT);
  endfunction

  // ****************************************
  // decode of the fall count
  // ****************************************
  // frame state is cleared by chip select itself: the clock stops between frames
  wire             frame_rst_b = rst_b & ~lnk.cs_b;                    // [R2]
  wire             first_fall  = (nf_q == '0);
  wire             conv_fall   = fall_reaches(nf_q, CONV_CLKS);
  wire [CNT_W-1:0] cal_end     = frame_first_q ? PCAL_CLKS : NCAL_CLKS; // [R15] [R17]
  wire             cal_fall    = fall_reaches(nf_q, cal_end);
  wire             bit_phase   = (nf_q >= FIRST_BIT) && (nf_q <= RES_CNT);
  wire [CNT_W-1:0] bit_idx     = RES_CNT - nf_q;
  wire             bit_w       = bit_phase ? word_q[bit_idx[3:0]] : 1'b0; // [R10] [R11]
  wire             trimming    = (nf_q > CONV_CLKS) && (nf_q < cal_end); // [R18]

  // ****************************************
  // sample hold
  // ****************************************
  // the input is frozen the instant the frame opens
  always_ff @(negedge lnk.cs_b) begin
    if (cen) begin
      hold_q <= ain_code; // [R4]
    end
  end

  // ****************************************
  // fall counter
  // ****************************************
  // saturates so that very long frames do not wrap into a new decode
  // the count and frame_first_q tell conversion, power-up trim and later trim apart
  always_ff @(negedge lnk.sclk or negedge frame_rst_b) begin
    if (!frame_rst_b) begin
      nf_q <= '0; // [R21]
    end else if (cen && (nf_q != NCAL_CLKS)) begin
      nf_q <= nf_q + FIRST_BIT; // [R21]
    end
  end

  // ****************************************
  // persistent state, kept across frames
  // ****************************************
  // only falls inside a frame move these; a stray clock while deselected is ignored
  wire        frame_en  = cen & ~lnk.cs_b;                        // [R2]
  wire [13:0] word_d    = first_q ? ZERO_CODE : result_q;         // [R7] [R8] [R15]
  wire        done_d    = conv_fall | (done_q & ~first_fall);
  wire [13:0] result_d  = sat_sub(hold_q, trim_q);                // [R20] [R13]
  // aborted trims never reach their last fall, so the old correction stays
  wire        trim_take = cal_fall && (nf_q > CONV_CLKS);         // [R16] [R18]

  // the outgoing word is chosen once, at the first fall, and then left alone
  always_ff @(negedge lnk.sclk or negedge rst_b) begin
    if (!rst_b) begin
      first_q       <= 1'b1;
      frame_first_q <= 1'b0;
      stale_q       <= 1'b0;
      word_q        <= ZERO_CODE;
    end else if (frame_en && first_fall) begin
      frame_first_q <= first_q;
      first_q       <= 1'b0;
      stale_q       <= ~done_q; // [R12]
      word_q        <= word_d;
    end
  end

  // set by the conversion fall, cleared at the first fall of the next frame
  always_ff @(negedge lnk.sclk or negedge rst_b) begin
    if (!rst_b) begin
      done_q <= 1'b1;
    end else if (frame_en) begin
      done_q <= done_d;
    end
  end

  // the conversion finishes on the 18th fall; later falls leave it alone
  always_ff @(negedge lnk.sclk or negedge rst_b) begin
    if (!rst_b) begin
      result_q <= ZERO_CODE;
    end else if (frame_en && conv_fall) begin
      result_q <= result_d; // [R13] [R20]
    end
  end

  // the correction survives every frame until power is removed or a later trim finishes
  always_ff @(negedge lnk.sclk or negedge rst_b) begin
    if (!rst_b) begin
      trim_q <= ZERO_CODE;
    end else if (frame_en && trim_take) begin
      trim_q <= zero_code; // [R13]
    end
  end

  // ****************************************
  // data launch
  // ****************************************
  // cleared while deselected, so the first level seen in a frame is zero
  always_ff @(posedge lnk.sclk or negedge frame_rst_b) begin
    if (!frame_rst_b) begin
      sdo_q <= 1'b0; // [R9]
    end else if (cen) begin
      sdo_q <= bit_w; // [R10] [R11] [R17]
    end
  end

  // ****************************************
  // state and outputs
  // ****************************************
  // sampling again after 18 falls or after a finished trim
  always_comb begin
    if (lnk.cs_b)
      state = sampling_state; // [R1] [R6] [R19]
    else if (nf_q < CONV_CLKS)
      state = converting_state; // [R4]
    else if (trimming)
      state = offset_trim_state; // [R13]
    else
      state = sampling_state; // [R19]
  end

  assign switches_closed = (state == sampling_state); // [R1] [R13]
  assign lnk.sdo_o       = sdo_q;
  assign lnk.sdo_oe_b    = lnk.cs_b;                  // [R3]
  assign trim_code       = trim_q;
  assign last_result     = result_q;
  assign word_invalid    = stale_q;                   // [R12]

endmodule

`default_nettype wire

// ===== rtl/sfc_pkg.sv
/*
  sfc_pkg: constants and types shared by both ends of the converter frame link.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package sfc_pkg;

  // ****************************************
  // result format
  // ****************************************
  localparam int unsigned RES_W = 14;
  localparam logic [13:0] NEG_FULL_CODE = 14'h2000;
  localparam logic [13:0] POS_FULL_CODE = 14'h1FFF;
  localparam logic [13:0] ZERO_CODE     = 14'h0000;

  // ****************************************
  // frame clock counts
  // ****************************************
  localparam int unsigned CNT_W = 7;
  localparam logic [6:0] CONV_CLKS  = 7'h12;  // 18 falls finish a conversion
  localparam logic [6:0] PCAL_CLKS  = 7'h18;  // 24 clocks in the first frame
  localparam logic [6:0] NCAL_CLKS  = 7'h40;  // 64 clocks in a later frame
  localparam logic [6:0] RES_CNT    = 7'h0E;  // result bits per frame
  localparam logic [6:0] FIRST_BIT  = 7'h01;
  localparam logic [6:0] FIRST_SAMP = 7'h02;  // host fall that sees the msb
  localparam logic [6:0] LAST_SAMP  = 7'h0F;  // host fall that sees the lsb

  // ****************************************
  // timing on the host clock
  // ****************************************
  localparam int unsigned MCLK_MHZ         = 250;
  localparam int unsigned MIN_SAMPLING_NS  = 230;
  localparam int unsigned SCLK_MAX_MHZ     = 24;
  localparam int unsigned ACQ_CYC_I = (MIN_SAMPLING_NS * MCLK_MHZ + 999) / 1000;
  localparam int unsigned HALF_CYC_I = (MCLK_MHZ + 2 * SCLK_MAX_MHZ - 1) / (2 * SCLK_MAX_MHZ);
  localparam int unsigned TMR_W = 6;
  localparam logic [5:0] ACQ_CYC  = 6'(ACQ_CYC_I);
  localparam logic [5:0] HALF_CYC = 6'(HALF_CYC_I);

  // ****************************************
  // device states
  // ****************************************
  typedef enum logic [1:0] {
    sampling_state,
    converting_state,
    offset_trim_state
  } sfc_state_e;

endpackage

// ===== rtl/sfc_link_if.sv
/*
  sfc_link_if: the three-wire frame link between host and converter.
  Assumes the host drives chip select and clock and the device drives data.
*/
`timescale 1ns/10ps
`default_nettype none

interface sfc_link_if;
  logic cs_b;      // frame select, low during a frame
  logic sclk;      // link clock made by the host
  logic sdo_o;     // device data out
  logic sdo_oe_b;  // device data enable, low while driving
  wire  sdo_line;  // resolved data wire

  // no keeper on this wire: while released it shows the inverse of the
  // last level, so a read outside a frame cannot pass for a held bit
  assign sdo_line = sdo_oe_b ? ~sdo_o : sdo_o;

  modport dev  (input cs_b, sclk, output sdo_o, sdo_oe_b);
  modport host (output cs_b, sclk, input sdo_line);
endinterface

`default_nettype wire

// ===== rtl/sfc_host.sv
/*
  sfc_host: host end that opens frames, makes the link clock and reads words.
  Assumes mclk at 250 MHz; the link clock is divided from it and driven out.
*/
`timescale 1ns/10ps
`default_nettype none

module sfc_host (
  // clock, reset, freeze
  input  wire logic              mclk,
  input  wire logic              rst_b,
  input  wire logic              cen,
  // link
  sfc_link_if.host               lnk,
  // frame request
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire logic [6:0]        req_clks,
  // frame answer
  output logic                   rsp_valid,
  output logic [13:0]            rsp_data,
  output logic                   boot_busy
);
  import sfc_pkg::*;

  typedef enum logic [2:0] {h_idle, h_setup, h_low, h_high, h_acq} sfc_hst_e;

  // ****************************************
  // storage
  // ****************************************
  sfc_hst_e         st_q;
  logic [TMR_W-1:0] tmr_q;
  logic [CNT_W-1:0] clk_q;
  logic [CNT_W-1:0] goal_q;
  logic [13:0]      shift_q;
  logic             boot_q;
  logic             cs_b_q;
  logic             sclk_q;
  logic             sdo_s1_q;
  logic             sdo_s2_q;
  logic             rsp_valid_q;
  logic [13:0]      rsp_data_q;

  // ****************************************
  // decode
  // ****************************************
  // short frames would leave the next word invalid, so they are lengthened
  wire [CNT_W-1:0] req_lo   = (req_clks < CONV_CLKS) ? CONV_CLKS : req_clks; // [R5]
  wire [CNT_W-1:0] req_goal = (req_lo > NCAL_CLKS) ? NCAL_CLKS : req_lo;
  wire             tmr_done = (tmr_q == '0);
  wire [CNT_W-1:0] fall_no  = clk_q + FIRST_BIT;
  wire             take_bit = (fall_no >= FIRST_SAMP) && (fall_no <= LAST_SAMP);
  wire             last_clk = (clk_q == goal_q);

  // ****************************************
  // data synchroniser
  // ****************************************
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sdo_s1_q <= 1'b0;
      sdo_s2_q <= 1'b0;
    end else if (cen) begin
      sdo_s1_q <= lnk.sdo_line;
      sdo_s2_q <= sdo_s1_q;
    end
  end

  // ****************************************
  // frame sequencer
  // ****************************************
  // bits are taken as the clock falls: launched a half period earlier, so settled
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_q        <= h_idle;
      tmr_q       <= '0;
      clk_q       <= '0;
      goal_q      <= '0;
      shift_q     <= ZERO_CODE;
      boot_q      <= 1'b1;
      cs_b_q      <= 1'b1;
      sclk_q      <= 1'b1;
      rsp_valid_q <= 1'b0;
      rsp_data_q  <= ZERO_CODE;
    end else if (cen) begin
      rsp_valid_q <= 1'b0;
      if (!tmr_done)
        tmr_q <= tmr_q - 6'h01;
      unique case (st_q)
        h_idle: begin
          if (boot_q || req_valid) begin
            goal_q <= boot_q ? PCAL_CLKS : req_goal; // [R14] [R15]
            boot_q <= 1'b0;
            clk_q  <= '0;
            cs_b_q <= 1'b0; // [R2]
            tmr_q  <= HALF_CYC - 6'h01;
            st_q   <= h_setup;
          end
        end
        h_setup: begin
          if (tmr_done) begin
            sclk_q <= 1'b0;
            tmr_q  <= HALF_CYC - 6'h01;
            st_q   <= h_low;
          end
        end
        h_low: begin
          if (tmr_done) begin
            sclk_q <= 1'b1;
            clk_q  <= clk_q + FIRST_BIT;
            tmr_q  <= HALF_CYC - 6'h01;
            st_q   <= h_high;
          end
        end
        h_high: begin
          if (tmr_done && last_clk) begin
            cs_b_q      <= 1'b1; // [R2]
            rsp_valid_q <= 1'b1;
            rsp_data_q  <= shift_q;
            tmr_q       <= ACQ_CYC - 6'h01;
            st_q        <= h_acq;
          end else if (tmr_done) begin
            sclk_q <= 1'b0;
            if (take_bit)
              shift_q <= {shift_q[12:0], sdo_s2_q};
            tmr_q  <= HALF_CYC - 6'h01;
            st_q   <= h_low;
          end
        end
        h_acq: begin
          if (tmr_done)
            st_q <= h_idle; // [R6]
        end
      endcase
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign lnk.cs_b  = cs_b_q;
  assign lnk.sclk  = sclk_q;
  assign req_ready = (st_q == h_idle) && !boot_q;
  assign rsp_valid = rsp_valid_q;
  assign rsp_data  = rsp_data_q;
  assign boot_busy = boot_q || (st_q != h_idle);

endmodule

`default_nettype wire

// ===== bench/sfc_link_chk.sv
/* sfc_link_chk: assertions on the frame link wires.
   Assumes mclk paces the host and rst_b is the power-up reset. */
`timescale 1ns/10ps
`default_nettype none
module sfc_link_chk (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // link
  input wire logic cs_b,
  input wire logic sclk,
  input wire logic sdo_o,
  input wire logic sdo_oe_b
);
  localparam int ACQ_MIN = (230 + 3) / 4;  // sampling time in whole cycles
  logic [6:0] fall_q;
  logic [5:0] hi_q;
  logic       first_q;
  // ****
  // helpers
  // ****
  // falls per frame, cleared by cs_b just as the device count is
  always_ff @(negedge sclk or posedge cs_b or negedge rst_b) begin
    if (!rst_b) fall_q <= 7'h00;
    else if (cs_b) fall_q <= 7'h00;
    else if (fall_q != 7'h7f) fall_q <= fall_q + 7'h01;
  end
  // idle cycles; power-up counts as fully settled
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) hi_q <= 6'h3f;
    else if (!cs_b) hi_q <= 6'h00;
    else if (hi_q != 6'h3f) hi_q <= hi_q + 6'h01;
  end
  // high until the first frame closes
  always_ff @(posedge cs_b or negedge rst_b) begin
    if (!rst_b) first_q <= 1'b1;
    else first_q <= 1'b0;
  end
  // ****
  // properties
  // ****
  property p_float;
    @(posedge mclk) disable iff (!rst_b) cs_b |-> sdo_oe_b;
  endproperty
  a_float: assert property (p_float) else $error("sdo driven while idle");
  property p_drive;
    @(posedge mclk) disable iff (!rst_b) !cs_b |-> !sdo_oe_b;
  endproperty
  a_drive: assert property (p_drive) else $error("sdo floats in frame");
  property p_idle;
    @(posedge mclk) disable iff (!rst_b) cs_b |-> sclk;
  endproperty
  a_idle: assert property (p_idle) else $error("sclk moved while idle");
  property p_lead;
    @(negedge sclk) disable iff (!rst_b) !cs_b && fall_q == 7'h00 |-> !sdo_o;
  endproperty
  a_lead: assert property (p_lead) else $error("leading bit not zero");
  property p_tail;
    @(negedge sclk) disable iff (!rst_b) !cs_b && fall_q >= 7'h0f |-> !sdo_o;
  endproperty
  a_tail: assert property (p_tail) else $error("tail bit not zero");
  property p_first;
    @(negedge sclk) disable iff (!rst_b) first_q && !cs_b |-> !sdo_o;
  endproperty
  a_first: assert property (p_first) else $error("boot word not zero");
  property p_falls;
    @(posedge mclk) disable iff (!rst_b)
      $rose(cs_b) |-> $past(fall_q) >= 7'h12 && $past(fall_q) <= 7'h40;
  endproperty
  a_falls: assert property (p_falls) else $error("frame fall count off");
  property p_acq;
    @(posedge mclk) disable iff (!rst_b) $fell(cs_b) |-> hi_q >= ACQ_MIN;
  endproperty
  a_acq: assert property (p_acq) else $error("sampling time too short");
  // main frame kinds
  c_conv: cover property (@(posedge mclk) $rose(cs_b) && $past(fall_q) == 7'h12);
  c_boot: cover property (@(posedge mclk) $rose(cs_b) && $past(fall_q) == 7'h18);
  c_cal: cover property (@(posedge mclk) $rose(cs_b) && $past(fall_q) == 7'h40);
endmodule
`default_nettype wire

// ===== bench/tb_sar_adc_serial_frame_control.sv
/* tb_sar_adc_serial_frame_control: host and converter ends on one link.
   Assumes the package, the interface and both ends compile first. */
`timescale 1ns/10ps
`default_nettype none
module tb_sar_adc_serial_frame_control;
  import sfc_pkg::*;
  // clock starts high so reset falls on a falling edge before any rising one;
  // the converter end has no clock in reset and needs a real reset edge
  logic        mclk      = 1'b1;
  logic        rst_b     = 1'b1;
  logic        req_valid = 1'b0;
  logic [6:0]  req_clks  = 7'h12;
  logic [13:0] ain_code  = 14'h0000;
  logic [13:0] zero_code = 14'h0000;
  logic        req_ready, rsp_valid, boot_busy, sw_closed, word_invalid;
  logic [13:0] rsp_data, trim_code, last_result, exp_word, exp_trim;
  sfc_state_e  state;
  int          fail_count  = 0;
  int          check_count = 0;
  int          cyc         = 0;
  // corner frames: boundary counts, clamping, saturation both ways
  logic [6:0]  cn [7] = '{7'h40, 7'h12, 7'h3f, 7'h40, 7'h13, 7'h05, 7'h7f};
  logic [13:0] ca [7] = '{14'h0abc, 14'h2001, 14'h1fff, 14'h0000, 14'h1ffd, 14'h0100, 14'h2000};
  logic [13:0] cz [7] = '{14'h0005, 14'h1234, 14'h0777, 14'h3ffb, 14'h0000, 14'h0222, 14'h0000};

  sfc_link_if sfc_link_if_i ();
  sfc_dev sfc_dev_i (.rst_b(rst_b), .cen(1'b1), .lnk(sfc_link_if_i.dev), .ain_code(ain_code),
    .zero_code(zero_code), .state(state), .switches_closed(sw_closed), .trim_code(trim_code),
    .last_result(last_result), .word_invalid(word_invalid));
  sfc_host sfc_host_i (.mclk(mclk), .rst_b(rst_b), .cen(1'b1), .lnk(sfc_link_if_i.host),
    .req_valid(req_valid), .req_ready(req_ready), .req_clks(req_clks), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .boot_busy(boot_busy));
  sfc_link_chk sfc_link_chk_i (.mclk(mclk), .rst_b(rst_b), .cs_b(sfc_link_if_i.cs_b),
    .sclk(sfc_link_if_i.sclk), .sdo_o(sfc_link_if_i.sdo_o), .sdo_oe_b(sfc_link_if_i.sdo_oe_b));

  // 4 ns host clock
  always #2 mclk = ~mclk;

  // ****
  // expectations
  // ****
  // two's complement difference, clipped to the code range
  function automatic logic [13:0] sat_sub(input logic [13:0] a, input logic [13:0] t);
    logic signed [14:0] d;
    d = $signed({a[13], a}) - $signed({t[13], t});
    if (d > 15'sh1fff) return 14'h1fff;
    if (d < -15'sh2000) return 14'h2000;
    return d[13:0];
  endfunction
  // the host bends any request into 18..64 clocks
  function automatic logic [6:0] clamp(input logic [6:0] n);
    return (n < 7'h12) ? 7'h12 : (n > 7'h40) ? 7'h40 : n;
  endfunction

  task automatic cmp(input logic [13:0] got, input logic [13:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_st(input sfc_state_e got, input sfc_state_e exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic final_report;
    $display("checks=%0d mismatches=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // hang guard: some 16 frames of under 900 cycles each
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      final_report();
    end
  end

  // ****
  // one frame through the host, checked at both ends
  // ****
  task automatic frame(input logic [6:0] n, input logic [13:0] a, input logic [13:0] z);
    int k;
    k = 0;
    while (req_ready !== 1'b1 && k < 2000) begin
      @(negedge mclk);
      k++;
    end
    if (k == 2000) fail_count++;
    cmp({13'h0000, boot_busy}, 14'h0000);
    req_valid = 1'b1;
    req_clks = n;
    ain_code = a;
    zero_code = z;
    @(negedge mclk);
    req_valid = 1'b0;
    repeat (3) @(negedge mclk);
    cmp_st(state, converting_state);
    cmp({13'h0000, sw_closed}, 14'h0000);
    k = 0;
    while (rsp_valid !== 1'b1 && k < 2000) begin
      @(negedge mclk);
      k++;
    end
    if (k == 2000) fail_count++;
    cmp(rsp_data, exp_word);
    // conversion at fall 18 still uses the old trim
    exp_word = sat_sub(a, exp_trim);
    if (clamp(n) == 7'h40) exp_trim = z;
    repeat (2) @(negedge mclk);
    cmp(trim_code, exp_trim);
    cmp(last_result, exp_word);
    cmp({13'h0000, word_invalid}, 14'h0000);
    cmp_st(state, sampling_state);
    cmp({13'h0000, sw_closed}, 14'h0001);
    cmp({13'h0000, boot_busy}, 14'h0001);
  endtask

  initial begin
    void'($urandom(32'h2e03));
    ain_code = 14'($urandom);
    zero_code = 14'($urandom);
    exp_word = ain_code;
    exp_trim = zero_code;
    @(negedge mclk);
    rst_b = 1'b0;
    repeat (20) @(negedge mclk);
    cmp({13'h0000, boot_busy}, 14'h0001);
    cmp_st(state, sampling_state);
    cmp({13'h0000, sw_closed}, 14'h0001);
    rst_b = 1'b1;
    $display("test reset done");
    for (int i = 0; i < 7; i++) frame(cn[i], ca[i], cz[i]);
    $display("test corners done");
    for (int i = 0; i < 8; i++) frame(7'($urandom_range(18, 64)), 14'($urandom), 14'($urandom));
    $display("test random done");
    final_report();
  end
endmodule
`default_nettype wire
